//--- common/ptmtc_regs.svh
/*
 * constants for the panel test-mode tape controller: clock, tape speeds, timing counts, pattern byte.
 * assumes a single 25 MHz mclk; included by bare name.
 */
`ifndef PTMTC_REGS_SVH
`define PTMTC_REGS_SVH
`define PTMTC_CLK_MHZ 25
`define PTMTC_PATTERN_BYTE 8'hAA
`define PTMTC_NORMAL_IPS 30
`define PTMTC_FAST_IPS 90
// write bit cell time in ns and derived cycle count (rounded down; ptmtc_top clamps it to at least one)
`define PTMTC_BIT_CELL_NS 400
`define PTMTC_BIT_CELL_CYC ((`PTMTC_BIT_CELL_NS * `PTMTC_CLK_MHZ) / 1000)
`endif

//--- common/ptmtc_pkg.sv
/*
 * types for the panel test-mode tape controller.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package ptmtc_pkg;
   typedef enum logic [2:0] {
      FN_IDLE,
      FN_FWD,
      FN_REV,
      FN_REWIND,
      FN_RECORD,
      FN_PLAY
   } ptmtc_fn_e;
endpackage : ptmtc_pkg

//--- rtl/ptmtc_top.sv
/*
 * panel test-mode tape controller: turns panel keys into tape motion, pattern writing and read enable.
 * assumes keys and tape sensors are asynchronous pins, active high; motor and direction outputs to transport are active low, fast_speed active high.
 */
`timescale 1ns/1ps
`include "ptmtc_regs.svh"
// Function
// R1: latched key runs until another key pressed
// R2: hold switch press cancels latched function
// R3: with hold, function runs while key held
// R4: forward with cartridge runs normal speed
// R5: tape end stops forward motion
// R6: reverse mirrors forward, tape backward
// R7: rewind runs backward at fast speed
// R8: rewind stops at tape beginning
// R9: record runs forward writing AA bytes
// R10: latched record stops at end or hold
// R11: record without cartridge still drives motor
// R12: with hold, record only while held
// R13: playback runs forward, enables reading
// R14: one function at a time, no overlap
// R15: reset leaves motor stopped, writing off
module ptmtc_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic panel_hold_switch,
   input wire logic forward_key,
   input wire logic reverse_key,
   input wire logic rewind_key,
   input wire logic pattern_record_key,
   input wire logic playback_key,
   input wire logic cartridge_present,
   input wire logic tape_end,
   input wire logic tape_begin,
   output logic motor_run_n,
   output logic forward_dir_n,
   output logic fast_speed,
   output logic write_enable,
   output logic write_clock,
   output logic write_data,
   output logic read_active_strobe
);
   localparam int CELL_CYC = (`PTMTC_BIT_CELL_CYC < 1) ? 1 : `PTMTC_BIT_CELL_CYC;
   localparam int CW = $clog2(CELL_CYC + 1);

   ////////////////////////////////////////////////////////////////////////////////
   // two-stage synchronisers for every key, switch and sensor pin; first stage feeds only the second
   logic [8:0] sync1;
   logic [8:0] sync2;
   always_ff @(posedge mclk) begin
      sync1 <= {panel_hold_switch, forward_key, reverse_key, rewind_key, pattern_record_key,
                playback_key, cartridge_present, tape_end, tape_begin};
      sync2 <= sync1;
   end
   wire hold = sync2[8];
   wire k_fwd = sync2[7];
   wire k_rev = sync2[6];
   wire k_rew = sync2[5];
   wire k_rec = sync2[4];
   wire k_play = sync2[3];
   wire cart = sync2[2];
   wire at_end = sync2[1];
   wire at_begin = sync2[0];

   // previous key levels give press edges
   logic [4:0] keys_q;
   logic hold_q;
   wire [4:0] keys = {k_fwd, k_rev, k_rew, k_rec, k_play};
   wire [4:0] press = keys & ~keys_q;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         keys_q <= 5'h1F;
         hold_q <= 1'b1;
      end else begin
         keys_q <= keys;
         hold_q <= hold;
      end
   end
   wire hold_press = hold & ~hold_q;

   ////////////////////////////////////////////////////////////////////////////////
   // key decode; fixed priority so only one function is ever picked
   function automatic ptmtc_pkg::ptmtc_fn_e pick(input logic [4:0] k);
      if (k[4]) pick = ptmtc_pkg::FN_FWD;
      else if (k[3]) pick = ptmtc_pkg::FN_REV;
      else if (k[2]) pick = ptmtc_pkg::FN_REWIND;
      else if (k[1]) pick = ptmtc_pkg::FN_RECORD;
      else if (k[0]) pick = ptmtc_pkg::FN_PLAY;
      else pick = ptmtc_pkg::FN_IDLE;
   endfunction : pick

   ptmtc_pkg::ptmtc_fn_e fn;
   ptmtc_pkg::ptmtc_fn_e next_fn;
   ptmtc_pkg::ptmtc_fn_e pend_fn;
   wire ptmtc_pkg::ptmtc_fn_e pressed_fn = pick(press);
   wire ptmtc_pkg::ptmtc_fn_e held_fn = pick(keys);

   // level of the key that owns a function; idle owns none, the two spare codes read as idle
   function automatic logic key_down(input ptmtc_pkg::ptmtc_fn_e f, input logic [4:0] k);
      unique case (f)
         ptmtc_pkg::FN_FWD: key_down = k[4];
         ptmtc_pkg::FN_REV: key_down = k[3];
         ptmtc_pkg::FN_REWIND: key_down = k[2];
         ptmtc_pkg::FN_RECORD: key_down = k[1];
         ptmtc_pkg::FN_PLAY: key_down = k[0];
         default: key_down = 1'b0;
      endcase
   endfunction : key_down

   // key of the running function still down (momentary mode)
   wire own_key_down = key_down(fn, keys); // R3 R12

   // tape direction of each function, used by the motor lines and by the sensor stops
   function automatic logic runs_forward(input ptmtc_pkg::ptmtc_fn_e f);
      runs_forward = f == ptmtc_pkg::FN_FWD || f == ptmtc_pkg::FN_RECORD || f == ptmtc_pkg::FN_PLAY;
   endfunction : runs_forward
   function automatic logic runs_backward(input ptmtc_pkg::ptmtc_fn_e f);
      runs_backward = f == ptmtc_pkg::FN_REV || f == ptmtc_pkg::FN_REWIND;
   endfunction : runs_backward
   // a function whose sensor already shows its limit is refused, so no one-cycle motor pulse at a limit
   function automatic logic blocked(input ptmtc_pkg::ptmtc_fn_e f, input logic e, input logic b);
      blocked = (runs_forward(f) && e) || (runs_backward(f) && b);
   endfunction : blocked

   // sensor stops: end stops forward functions, beginning stops backward ones
   wire fwd_fn = runs_forward(fn);
   wire stop_end = fwd_fn && at_end; // R5 R10
   wire stop_begin = runs_backward(fn) && at_begin; // R8
   // cartridge needed for all but record, which drives the motor regardless
   function automatic logic needs_cart(input ptmtc_pkg::ptmtc_fn_e f);
      needs_cart = f != ptmtc_pkg::FN_RECORD && f != ptmtc_pkg::FN_IDLE;
   endfunction : needs_cart

   // function selection: new press replaces old, hold cancels, momentary mode follows keys;
   // a function parked by a switch takes over again once its idle cycle has passed
   always_comb begin
      next_fn = (fn == ptmtc_pkg::FN_IDLE) ? pend_fn : fn; // R1 R14
      if (hold_press) begin
         next_fn = ptmtc_pkg::FN_IDLE; // R2 R10
      end else if (hold) begin
         if (own_key_down) next_fn = fn; // R3 R12
         else next_fn = held_fn; // R3 R6
      end else if (pressed_fn != ptmtc_pkg::FN_IDLE) begin
         next_fn = pressed_fn; // R1 R6
      end
      if (needs_cart(next_fn) && !cart) next_fn = ptmtc_pkg::FN_IDLE; // R4 R11 R13
      if (blocked(next_fn, at_end, at_begin)) next_fn = ptmtc_pkg::FN_IDLE; // R5 R8 R10
   end

   // pass through idle when switching so both directions never drive together
   wire switching = fn != ptmtc_pkg::FN_IDLE && next_fn != fn;
   always_ff @(posedge mclk) begin
      if (!rst_n) fn <= ptmtc_pkg::FN_IDLE; // R15
      else if (switching) fn <= ptmtc_pkg::FN_IDLE; // R14
      else fn <= next_fn;
   end

   // the new function waits here through the idle cycle; the press edge is gone by then
   always_ff @(posedge mclk) begin
      if (!rst_n) pend_fn <= ptmtc_pkg::FN_IDLE; // R15
      else if (switching) pend_fn <= next_fn; // R1 R14
      else pend_fn <= ptmtc_pkg::FN_IDLE;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pattern serialiser: one bit per two cell counts (write_clock low then high), msb first, byte repeats forever
   logic [CW-1:0] cell_cnt;
   logic [2:0] bit_idx;
   logic cell_half;
   localparam logic [7:0] PATTERN = `PTMTC_PATTERN_BYTE;
   wire recording = fn == ptmtc_pkg::FN_RECORD;
   wire cell_tick = cell_cnt == CW'(CELL_CYC - 1);
   always_ff @(posedge mclk) begin
      if (!rst_n || !recording) begin
         cell_cnt <= '0;
         bit_idx <= 3'h7;
         cell_half <= 1'b0;
      end else if (cell_tick) begin
         cell_cnt <= '0;
         cell_half <= ~cell_half;
         if (cell_half) bit_idx <= bit_idx - 3'h1; // R9
      end else begin
         cell_cnt <= cell_cnt + CW'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registered transport outputs, all low-active drive lines idle high
   wire run = fn != ptmtc_pkg::FN_IDLE;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         motor_run_n <= 1'b1;
         forward_dir_n <= 1'b1;
         fast_speed <= 1'b0;
         write_enable <= 1'b0;
         write_clock <= 1'b0;
         write_data <= 1'b0;
         read_active_strobe <= 1'b0;
      end else begin
         motor_run_n <= ~run; // R4 R11
         forward_dir_n <= ~fwd_fn; // R6 R11
         fast_speed <= fn == ptmtc_pkg::FN_REWIND; // R7
         write_enable <= recording; // R9
         write_clock <= recording & cell_half;
         write_data <= recording & PATTERN[bit_idx]; // R9
         read_active_strobe <= fn == ptmtc_pkg::FN_PLAY; // R13
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   property p_hold_cancels;
      @(posedge mclk) disable iff (!rst_n) hold_press |=> fn == ptmtc_pkg::FN_IDLE;
   endproperty
   a_hold_cancels: assert property (p_hold_cancels) else $error("hold press left function running"); // R2
   property p_latch;
      @(posedge mclk) disable iff (!rst_n)
         (!hold && fn == ptmtc_pkg::FN_FWD && !stop_end && press == 5'h00 && cart) |=> fn == ptmtc_pkg::FN_FWD;
   endproperty
   a_latch: assert property (p_latch) else $error("latched forward dropped"); // R1
   property p_momentary;
      @(posedge mclk) disable iff (!rst_n)
         (hold && !hold_press && fn == ptmtc_pkg::FN_FWD && !k_fwd) |=> fn != ptmtc_pkg::FN_FWD;
   endproperty
   a_momentary: assert property (p_momentary) else $error("momentary forward kept running"); // R3
   property p_end_stop;
      @(posedge mclk) disable iff (!rst_n) (fwd_fn && at_end) |=> fn == ptmtc_pkg::FN_IDLE;
   endproperty
   a_end_stop: assert property (p_end_stop) else $error("tape end did not stop"); // R5
   property p_begin_stop;
      @(posedge mclk) disable iff (!rst_n) stop_begin |=> fn == ptmtc_pkg::FN_IDLE;
   endproperty
   a_begin_stop: assert property (p_begin_stop) else $error("tape begin did not stop"); // R8
   property p_rewind_fast;
      @(posedge mclk) disable iff (!rst_n) fn == ptmtc_pkg::FN_REWIND |=> fast_speed && !motor_run_n && forward_dir_n;
   endproperty
   a_rewind_fast: assert property (p_rewind_fast) else $error("rewind not fast backward"); // R7
   property p_record_drive;
      @(posedge mclk) disable iff (!rst_n) recording |=> !motor_run_n && !forward_dir_n && write_enable;
   endproperty
   a_record_drive: assert property (p_record_drive) else $error("record not driving forward"); // R9 R11
   property p_play_read;
      @(posedge mclk) disable iff (!rst_n) fn == ptmtc_pkg::FN_PLAY |=> read_active_strobe && !write_enable;
   endproperty
   a_play_read: assert property (p_play_read) else $error("playback not reading"); // R13
   property p_via_idle;
      @(posedge mclk) disable iff (!rst_n) (run && $changed(fn)) |-> $past(fn) == ptmtc_pkg::FN_IDLE;
   endproperty
   a_via_idle: assert property (p_via_idle) else $error("function changed without idle gap"); // R14
   property p_reset_idle;
      @(posedge mclk) !rst_n |=> motor_run_n && !write_enable;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("reset left motor or write on"); // R15

   ////////////////////////////////////////////////////////////////////////////////
   // output checks look one edge after the state, since every output is registered
   // only record may run with no cartridge loaded
   property p_cart_needed;
      @(posedge mclk) disable iff (!rst_n) !cart |=> fn == ptmtc_pkg::FN_IDLE || fn == ptmtc_pkg::FN_RECORD;
   endproperty
   a_cart_needed: assert property (p_cart_needed) else $error("function ran without cartridge"); // R4 R13
   // the first bit on tape is the top bit of the pattern byte
   property p_first_bit;
      @(posedge mclk) disable iff (!rst_n) $rose(recording) |=> write_data == PATTERN[7];
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("pattern did not start with top bit"); // R9
   // momentary record ends with its key
   property p_momentary_rec;
      @(posedge mclk) disable iff (!rst_n) (hold && !hold_press && recording && !k_rec) |=> !recording;
   endproperty
   a_momentary_rec: assert property (p_momentary_rec) else $error("momentary record kept running"); // R12
   // forward runs the motor forward at normal speed
   property p_forward_drive;
      @(posedge mclk) disable iff (!rst_n)
         fn == ptmtc_pkg::FN_FWD |=> !motor_run_n && !forward_dir_n && !fast_speed;
   endproperty
   a_forward_drive: assert property (p_forward_drive) else $error("forward not normal speed forward"); // R4
   // reverse runs the motor backward at normal speed
   property p_reverse_drive;
      @(posedge mclk) disable iff (!rst_n)
         fn == ptmtc_pkg::FN_REV |=> !motor_run_n && forward_dir_n && !fast_speed;
   endproperty
   a_reverse_drive: assert property (p_reverse_drive) else $error("reverse not normal speed backward"); // R6
   // playback moves the tape forward at normal speed
   property p_play_dir;
      @(posedge mclk) disable iff (!rst_n)
         fn == ptmtc_pkg::FN_PLAY |=> !motor_run_n && !forward_dir_n && !fast_speed;
   endproperty
   a_play_dir: assert property (p_play_dir) else $error("playback not moving forward"); // R13
   // with nothing selected, motor, writing and reading all rest
   property p_idle_quiet;
      @(posedge mclk) disable iff (!rst_n)
         fn == ptmtc_pkg::FN_IDLE |=> motor_run_n && forward_dir_n && !write_enable && !read_active_strobe;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("idle left a drive line active"); // R15
   // the write lines stay low unless recording
   property p_write_only_record;
      @(posedge mclk) disable iff (!rst_n) !recording |=> !write_enable && !write_clock && !write_data;
   endproperty
   a_write_only_record: assert property (p_write_only_record) else $error("write lines active"); // R9
   // a parked function starts once the idle cycle is over
   property p_pend_lands;
      @(posedge mclk) disable iff (!rst_n)
         (fn == ptmtc_pkg::FN_IDLE && pend_fn != ptmtc_pkg::FN_IDLE && !hold && press == 5'h00 && cart
            && !blocked(pend_fn, at_end, at_begin)) |=> fn == $past(pend_fn);
   endproperty
   a_pend_lands: assert property (p_pend_lands) else $error("switched function never started"); // R1

   // covers for the main scenarios
   c_record: cover property (@(posedge mclk) disable iff (!rst_n) recording ##1 write_data);
   c_rewind: cover property (@(posedge mclk) disable iff (!rst_n) fn == ptmtc_pkg::FN_REWIND ##1 stop_begin);
   c_play: cover property (@(posedge mclk) disable iff (!rst_n) read_active_strobe);
   c_switch: cover property (@(posedge mclk) disable iff (!rst_n) fn == ptmtc_pkg::FN_FWD ##2 fn == ptmtc_pkg::FN_REV);
   c_bare_record: cover property (@(posedge mclk) disable iff (!rst_n) !cart && recording);
endmodule : ptmtc_top

//--- bench/ptmtc_transport_model.sv
/*
 * tape transport model: a tape position moved by the motor lines, with end and beginning sensors.
 * assumes active-low motor and direction lines and one shared mclk.
 */
`timescale 1ns/1ps
module ptmtc_transport_model #(parameter int LEN = 600) (
   input wire logic mclk,
   input wire logic motor_run_n,
   input wire logic forward_dir_n,
   input wire logic fast_speed,
   output logic tape_end,
   output logic tape_begin
);
   int pos = LEN / 2;
   ////////////////////////////////////////////////////////////////
   // tape moves on the falling edge so sensors never change at the sampling edge
   always @(negedge mclk) begin
      if (!motor_run_n && !forward_dir_n && pos < LEN) begin
         pos <= pos + (fast_speed ? 3 : 1);
      end else if (!motor_run_n && forward_dir_n && pos > 0) begin
         pos <= pos - (fast_speed ? 3 : 1);
      end
   end
   // sensors hold as long as the tape sits at or past a limit
   assign tape_end = (pos >= LEN);
   assign tape_begin = (pos <= 0);
endmodule : ptmtc_transport_model

//--- bench/tb.sv
/*
 * self-checking bench: driver notes expected output states, a monitor compares them.
 * assumes ptmtc_top and the transport model are compiled before it.
 */
`timescale 1ns/1ps
`include "ptmtc_regs.svh"
module tb;
   // key order in keys: forward, reverse, rewind, record, playback
   localparam logic [4:0] KEY_T[3] = '{5'h10, 5'h08, 5'h01};
   localparam logic [4:0] EXP_T[3] = '{5'h00, 5'h08, 5'h01};
   localparam logic [7:0] PATTERN = `PTMTC_PATTERN_BYTE;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic hold = 1'b0;
   logic cart = 1'b1;
   logic [4:0] keys = 5'h00;
   logic tape_end, tape_begin, motor_run_n, forward_dir_n, fast_speed;
   logic write_enable, write_clock, write_data, read_active_strobe;
   logic [4:0] exp_q[$];
   logic [31:0] lfsr = 32'h45BB7559;
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;
   event probe;
   initial forever #20 mclk = ~mclk;
   ptmtc_top ptmtc_top_i (.mclk(mclk), .rst_n(rst_n), .panel_hold_switch(hold), .forward_key(keys[4]),
      .reverse_key(keys[3]), .rewind_key(keys[2]), .pattern_record_key(keys[1]), .playback_key(keys[0]),
      .cartridge_present(cart), .tape_end(tape_end), .tape_begin(tape_begin), .motor_run_n(motor_run_n),
      .forward_dir_n(forward_dir_n), .fast_speed(fast_speed), .write_enable(write_enable),
      .write_clock(write_clock), .write_data(write_data), .read_active_strobe(read_active_strobe));
   ptmtc_transport_model ptmtc_transport_model_i (.mclk(mclk), .motor_run_n(motor_run_n),
      .forward_dir_n(forward_dir_n), .fast_speed(fast_speed), .tape_end(tape_end), .tape_begin(tape_begin));
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next
   task automatic compare(input string what, input logic [4:0] seen, input logic [4:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : compare
   // random gap well beyond the five-edge answer latency
   task automatic gap();
      lfsr = lfsr_next(lfsr);
      repeat (8 + lfsr[2:0]) @(negedge mclk);
   endtask : gap
   task automatic note(input logic [4:0] e);
      exp_q.push_back(e);
      ->probe;
   endtask : note
   task automatic press(input logic [4:0] k);
      keys = k;
      repeat (3) @(negedge mclk);
      keys = 5'h00;
      gap();
   endtask : press
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////
   // monitor: oldest note against the settled outputs
   always @(probe) begin
      #1;
      compare("outputs", {motor_run_n, forward_dir_n, fast_speed, write_enable, read_active_strobe},
         exp_q.pop_front());
   end
   // hang guard, far above the thousand or so cycles the run needs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end
   initial begin
      int idx;
      logic prev;
      time tw;
      repeat (5) @(negedge mclk);
      note(5'h18);
      rst_n = 1'b1;
      gap();
      for (int i = 0; i < 6; i++) begin
         idx = int'(lfsr_next(lfsr) % 3);
         press(KEY_T[idx]);
         note(EXP_T[idx]);
      end
      $display("test latched done");
      hold = 1'b1;
      gap();
      note(5'h18);
      keys = 5'h10;
      gap();
      note(5'h00);
      keys = 5'h00;
      gap();
      note(5'h18);
      keys = 5'h02;
      @(posedge write_clock);
      @(negedge mclk);
      compare("first write bit", {4'h0, write_data}, {4'h0, PATTERN[7]});
      note(5'h02);
      keys = 5'h00;
      gap();
      note(5'h18);
      hold = 1'b0;
      $display("test hold done");
      press(5'h04);
      note(5'h0C);
      wait (tape_begin);
      gap();
      note(5'h18);
      $display("test rewind done");
      cart = 1'b0;
      press(5'h02);
      note(5'h02);
      @(posedge write_clock);
      @(negedge mclk);
      prev = write_data;
      tw = $time;
      for (int i = 0; i < 8; i++) begin
         @(posedge write_clock);
         @(negedge mclk);
         compare("write_data", {4'h0, write_data}, {4'h0, ~prev});
         compare("write_clock period", 5'(($time - tw) / 40), 5'(2 * `PTMTC_BIT_CELL_CYC));
         prev = write_data;
         tw = $time;
      end
      hold = 1'b1;
      gap();
      note(5'h18);
      hold = 1'b0;
      cart = 1'b1;
      gap();
      $display("test record done");
      press(5'h10);
      note(5'h00);
      wait (tape_end);
      gap();
      note(5'h18);
      $display("test end done");
      press(5'h08);
      note(5'h08);
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      note(5'h18);
      rst_n = 1'b1;
      gap();
      note(5'h18);
      $display("test reset done");
      tally_and_finish();
   end
endmodule : tb
